/* File: bench/dual_prescaled_reload_timer_tb.sv */
// self-checking bench for the dual reload timer
// assumes the port checker is bound separately
`timescale 1ns/1ps
`include "timer_regs.vh"
module dual_prescaled_reload_timer_tb;
    // ==========================================
    // stimulus and checks
    reg clk_in = 1'b0, resetn_in = 1'b0, psel = 1'b0, pen = 1'b0, pwr = 1'b0, err;
    reg [11:0] paddr = 12'h0;
    reg [31:0] pwdata = 32'h0, rd, r0;
    wire [31:0] prdata;
    wire pready, perr, f0, f1;
    integer n_mismatch = 0, n_tests = 0, cyc = 0, i;
    dual_prescaled_reload_timer u_dual_prescaled_reload_timer (.clk_in(clk_in),
        .resetn_in(resetn_in), .psel_in(psel), .penable_in(pen), .pwrite_in(pwr),
        .paddr_in(paddr), .pwdata_in(pwdata), .prdata_out(prdata), .pready_out(pready),
        .pslverr_out(perr), .t0_overflow_out(f0), .t1_overflow_out(f1));
    initial forever #2.5 clk_in = ~clk_in;
    task wrap_up;
        begin
            $display("tests %0d mismatches %0d", n_tests, n_mismatch);
            if (n_mismatch == 0 && n_tests > 0) $display("Simulation passed");
            else $display("Simulation failed");
            $finish;
        end
    endtask
    always @(posedge clk_in) begin
        cyc = cyc + 1;
        if (cyc == 40000) begin
            n_mismatch = n_mismatch + 1;
            wrap_up;
        end
    end
    task apb(input w, input [11:0] a, input [31:0] d);
        begin
            @(posedge clk_in);
            psel <= 1'b1; pwr <= w; paddr <= a; pwdata <= d;
            @(posedge clk_in);
            pen <= 1'b1;
            @(posedge clk_in);
            while (pready !== 1'b1) @(posedge clk_in);
            rd = prdata; err = perr; psel <= 1'b0; pen <= 1'b0;
        end
    endtask
    task chk(input [31:0] g, input [31:0] x);
        begin
            n_tests = n_tests + 1;
            if (g !== x) begin
                n_mismatch = n_mismatch + 1;
                $display("BAD t=%0t got %h exp %h", $time, g, x);
            end
        end
    endtask
    task t_reset;
        begin
            apb(0, `T0_CTRL_ADDR, 0); chk(rd, {24'h000000, `CTRL_RESET});
            apb(0, `T1_CTRL_ADDR, 0); chk(rd, {24'h000000, `CTRL_RESET});
            apb(0, 12'h0fc, 0); chk(err, 1);
            $display("reset done");
        end
    endtask
    task t_overflow;
        begin
            apb(1, `T0_COUNT_ADDR, 32'hfd);
            apb(0, `T0_COUNT_ADDR, 0); chk(rd, 32'h0);
            apb(1, `T0_CTRL_ADDR, 32'h90);
            for (i = 0; i < 5000 && f0 !== 1'b1; i = i + 1) @(posedge clk_in);
            chk(f0, 1);
            apb(0, `IRQ_CTRL_ADDR, 0); chk(rd, 32'h4);
            apb(0, `T0_COUNT_ADDR, 0); chk(rd, 32'hfd);
            apb(1, `T0_CTRL_ADDR, 32'h80);
            apb(0, `T0_COUNT_ADDR, 0); chk(rd, 32'hfd);
            repeat (100) @(posedge clk_in);
            apb(0, `T0_COUNT_ADDR, 0); chk(rd, 32'hfd);
            apb(0, `IRQ_CTRL_ADDR, 0); chk(rd, 32'h4);
            apb(1, `IRQ_CTRL_ADDR, 0); apb(0, `IRQ_CTRL_ADDR, 0); chk(rd, 32'h0);
            repeat (2) @(posedge clk_in);
            chk(f0, 0);
            $display("overflow done");
        end
    endtask
    task t_div;
        begin
            for (i = 0; i < 8; i = i + 1) begin
                apb(0, `T1_COUNT_ADDR, 0); r0 = rd;
                apb(1, `T1_CTRL_ADDR, 32'h90 | i);
                repeat ((32 << i) + (8 << i)) @(posedge clk_in);
                apb(1, `T1_CTRL_ADDR, 32'h80 | i); apb(0, `T1_COUNT_ADDR, 0);
                chk((rd - r0) & 32'hff, 32'h2);
            end
            $display("divider done");
        end
    endtask
    task t_timer1;
        begin
            apb(1, `T1_COUNT_ADDR, 32'hf0);
            apb(1, `T1_CTRL_ADDR, 32'h90);
            for (i = 0; i < 5000 && f1 !== 1'b1; i = i + 1) @(posedge clk_in);
            chk(f1, 1);
            apb(0, `IRQ_CTRL_ADDR, 0); chk(rd, 32'h8);
            apb(0, `T1_COUNT_ADDR, 0); chk(rd, 32'hf0);
            apb(1, `T1_CTRL_ADDR, 32'h80);
            apb(1, `IRQ_CTRL_ADDR, 32'h8); apb(0, `IRQ_CTRL_ADDR, 0); chk(rd, 32'h8);
            apb(1, `IRQ_CTRL_ADDR, 32'h4); apb(0, `IRQ_CTRL_ADDR, 0); chk(rd, 32'h0);
            repeat (2) @(posedge clk_in);
            chk(f1, 0);
            $display("timer1 done");
        end
    endtask
    initial begin
        repeat (6) @(posedge clk_in);
        resetn_in <= 1'b1;
        t_reset;
        t_overflow;
        t_div;
        t_timer1;
        wrap_up;
    end
endmodule

/* File: bench/timer_monitor.sv */
// port checker for the dual reload timer
// assumes bind onto the top module, one clock domain
`timescale 1ns/1ps
`include "timer_regs.vh"
module timer_monitor (
    input wire clk_in, input wire resetn_in,
    input wire psel_in, input wire penable_in, input wire pwrite_in,
    input wire [11:0] paddr_in, input wire [31:0] pwdata_in,
    input wire [31:0] prdata_out, input wire pready_out, input wire pslverr_out,
    input wire t0_overflow_out, input wire t1_overflow_out
);
    // ==========================================
    // bus and flag relations
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!resetn_in);
    wire acc = psel_in && penable_in;
    wire ctl = paddr_in == `T0_CTRL_ADDR || paddr_in == `T1_CTRL_ADDR;
    wire hit = ctl || paddr_in == `T0_COUNT_ADDR || paddr_in == `T1_COUNT_ADDR
        || paddr_in == `IRQ_CTRL_ADDR;
    wire clr = psel_in && pwrite_in && paddr_in == `IRQ_CTRL_ADDR;
    a_ready_answer: assert property (acc && !pready_out |=> pready_out) else $error("late");
    a_ready_pulse: assert property (pready_out |=> !pready_out) else $error("long");
    a_ready_cause: assert property (!acc |=> !pready_out) else $error("stray");
    a_rdata_idle: assert property (!pready_out |-> prdata_out == 32'h0) else $error("rd");
    a_err_map: assert property (pready_out |-> pslverr_out == !hit) else $error("err");
    a_upper_zero: assert property (pready_out |-> prdata_out[31:8] == 24'h0) else $error("hi");
    a_ctrl_fixed: assert property (pready_out && !pwrite_in && ctl |->
        prdata_out[6:5] == 2'b00 && prdata_out[7] != prdata_out[3]) else $error("ctl");
    a_flag_sticky: assert property ($fell(t0_overflow_out) || $fell(t1_overflow_out) |->
        $past(clr, 1) || $past(clr, 2) || $past(clr, 3)) else $error("flag");
    c_write: cover property (pready_out && pwrite_in);
    c_error: cover property (pready_out && pslverr_out);
    c_flag: cover property ($rose(t0_overflow_out));
endmodule
bind dual_prescaled_reload_timer timer_monitor u_timer_monitor (.clk_in(clk_in),
    .resetn_in(resetn_in), .psel_in(psel_in), .penable_in(penable_in),
    .pwrite_in(pwrite_in), .paddr_in(paddr_in), .pwdata_in(pwdata_in),
    .prdata_out(prdata_out), .pready_out(pready_out), .pslverr_out(pslverr_out),
    .t0_overflow_out(t0_overflow_out), .t1_overflow_out(t1_overflow_out));

/* File: core/dual_prescaled_reload_timer.v */
// two 8-bit reload timers with per-timer prescaler, apb register slave
// assumes a single 200 mhz clock and a synchronous apb master on the same clock
//
// Local design decision: the APB slave port.
`timescale 1ns/1ps
`include "timer_regs.vh"

module dual_prescaled_reload_timer #(
    parameter WIDTH = 8
) (
    // clock and reset
    input wire clk_in,
    input wire resetn_in,
    // apb slave
    input wire psel_in,
    input wire penable_in,
    input wire pwrite_in,
    input wire [11:0] paddr_in,
    input wire [31:0] pwdata_in,
    output reg [31:0] prdata_out,
    output reg pready_out,
    output reg pslverr_out,
    // overflow request levels
    output reg t0_overflow_out,
    output reg t1_overflow_out
);

    // ==========================================================
    // helpers
    // high on the last clock of each prescaler period
    function tick_sel;
        input [`PRESCALE_BITS-1:0] pre;
        input [2:0] code;
        reg [`PRESCALE_BITS-1:0] mask;
        begin
            mask = ~({`PRESCALE_BITS{1'b1}} << (`DIV_BASE_LOG2 + code));
            tick_sel = ((pre & mask) == mask);
        end
    endfunction

    // a stopped prescaler is held at zero so each start begins a full period
    function [`PRESCALE_BITS-1:0] next_pre;
        input [`PRESCALE_BITS-1:0] pre;
        input en;
        begin
            if (en) begin
                next_pre = pre + {{(`PRESCALE_BITS-1){1'b0}}, 1'b1};
            end else begin
                next_pre = {`PRESCALE_BITS{1'b0}};
            end
        end
    endfunction

    // counting up; past all ones the preload value comes back
    function [WIDTH-1:0] next_count;
        input [WIDTH-1:0] cnt;
        input [WIDTH-1:0] load;
        input tick;
        begin
            if (tick && (&cnt)) begin
                next_count = load;
            end else if (tick) begin
                next_count = cnt + {{(WIDTH-1){1'b0}}, 1'b1};
            end else begin
                next_count = cnt;
            end
        end
    endfunction

    // software value for the preload; the live count is not touched
    function [WIDTH-1:0] next_load;
        input [WIDTH-1:0] load;
        input we;
        input [31:0] data;
        begin
            if (we) begin
                next_load = data[WIDTH-1:0];
            end else begin
                next_load = load;
            end
        end
    endfunction

    // only enable and divider bits are stored; once written, bit 7 reads one, bits 6, 5, 3 zero
    function [7:0] next_ctrl;
        input [7:0] ctrl;
        input we;
        input [7:0] data;
        begin
            if (we) begin
                next_ctrl = (data & `CTRL_WMASK) | `CTRL_FIXED;
            end else begin
                next_ctrl = ctrl;
            end
        end
    endfunction

    // a hardware set wins over a software clear in the same cycle
    function next_flag;
        input flag;
        input raise;
        input drop;
        begin
            if (raise) begin
                next_flag = 1'b1;
            end else if (drop) begin
                next_flag = 1'b0;
            end else begin
                next_flag = flag;
            end
        end
    endfunction

    // ==========================================================
    // state
    reg [`PRESCALE_BITS-1:0] pre0_q;
    reg [`PRESCALE_BITS-1:0] pre1_q;
    reg [WIDTH-1:0] cnt0_q;
    reg [WIDTH-1:0] cnt1_q;
    reg [WIDTH-1:0] load0_q;
    reg [WIDTH-1:0] load1_q;
    reg [7:0] ctrl0_q;
    reg [7:0] ctrl1_q;
    reg ovf0_q;
    reg ovf1_q;

    // a write lands at the edge that completes the access
    wire acc = psel_in & penable_in & ~pready_out;
    wire wr = psel_in & penable_in & pready_out & pwrite_in;
    wire hit_c0 = (paddr_in == `T0_COUNT_ADDR);
    wire hit_k0 = (paddr_in == `T0_CTRL_ADDR);
    wire hit_c1 = (paddr_in == `T1_COUNT_ADDR);
    wire hit_k1 = (paddr_in == `T1_CTRL_ADDR);
    wire hit_ir = (paddr_in == `IRQ_CTRL_ADDR);
    wire mapped = hit_c0 | hit_k0 | hit_c1 | hit_k1 | hit_ir;

    wire en0 = ctrl0_q[`CTRL_EN_BIT];
    wire en1 = ctrl1_q[`CTRL_EN_BIT];
    wire tick0 = en0 & tick_sel(pre0_q, ctrl0_q[`CTRL_DIV_MSB:0]);
    wire tick1 = en1 & tick_sel(pre1_q, ctrl1_q[`CTRL_DIV_MSB:0]);
    wire wrap0 = tick0 & (&cnt0_q);
    wire wrap1 = tick1 & (&cnt1_q);

    // ==========================================================
    // next state
    wire [`PRESCALE_BITS-1:0] pre0_d = next_pre(pre0_q, en0);
    wire [`PRESCALE_BITS-1:0] pre1_d = next_pre(pre1_q, en1);
    wire [WIDTH-1:0] cnt0_d = next_count(cnt0_q, load0_q, tick0);
    wire [WIDTH-1:0] cnt1_d = next_count(cnt1_q, load1_q, tick1);
    wire [WIDTH-1:0] load0_d = next_load(load0_q, wr && hit_c0, pwdata_in);
    wire [WIDTH-1:0] load1_d = next_load(load1_q, wr && hit_c1, pwdata_in);
    wire [7:0] ctrl0_d = next_ctrl(ctrl0_q, wr && hit_k0, pwdata_in[7:0]);
    wire [7:0] ctrl1_d = next_ctrl(ctrl1_q, wr && hit_k1, pwdata_in[7:0]);
    wire clr0 = wr && hit_ir && !pwdata_in[`IRQ_T0_BIT];
    wire clr1 = wr && hit_ir && !pwdata_in[`IRQ_T1_BIT];
    wire ovf0_d = next_flag(ovf0_q, wrap0, clr0);
    wire ovf1_d = next_flag(ovf1_q, wrap1, clr1);

    // ==========================================================
    // prescalers and counters
    always @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            pre0_q <= 11'h000;
            pre1_q <= 11'h000;
            cnt0_q <= {WIDTH{1'b0}};
            cnt1_q <= {WIDTH{1'b0}};
        end else begin
            pre0_q <= pre0_d;
            pre1_q <= pre1_d;
            cnt0_q <= cnt0_d;
            cnt1_q <= cnt1_d;
        end
    end

    // ==========================================================
    // registers written by software
    always @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            load0_q <= {WIDTH{1'b0}};
            load1_q <= {WIDTH{1'b0}};
            ctrl0_q <= `CTRL_RESET;
            ctrl1_q <= `CTRL_RESET;
            ovf0_q <= 1'b0;
            ovf1_q <= 1'b0;
        end else begin
            load0_q <= load0_d;
            load1_q <= load1_d;
            ctrl0_q <= ctrl0_d;
            ctrl1_q <= ctrl1_d;
            ovf0_q <= ovf0_d;
            ovf1_q <= ovf1_d;
        end
    end

    // ==========================================================
    // apb answer, one wait state per access
    always @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            prdata_out <= 32'h00000000;
            pready_out <= 1'b0;
            pslverr_out <= 1'b0;
            t0_overflow_out <= 1'b0;
            t1_overflow_out <= 1'b0;
        end else begin
            t0_overflow_out <= ovf0_q;
            t1_overflow_out <= ovf1_q;
            pready_out <= acc;
            pslverr_out <= acc & ~mapped;
            prdata_out <= 32'h00000000;
            if (acc && !pwrite_in) begin
                if (hit_c0) begin
                    prdata_out <= {24'h000000, cnt0_q};
                end else if (hit_k0) begin
                    prdata_out <= {24'h000000, ctrl0_q};
                end else if (hit_c1) begin
                    prdata_out <= {24'h000000, cnt1_q};
                end else if (hit_k1) begin
                    prdata_out <= {24'h000000, ctrl1_q};
                end else if (hit_ir) begin
                    prdata_out <= {28'h0000000, ovf1_q, ovf0_q, 2'b00};
                end
            end
        end
    end

endmodule

/* File: core/timer_regs.vh */
// register map, fields, reset values and divider constants for the dual reload timer
// assumes byte addresses = 4 * register index on a 32-bit apb bus
`ifndef TIMER_REGS_VH
`define TIMER_REGS_VH

// ==========================================================
// register indices and byte addresses
`define T0_COUNT_IDX 8'h0d
`define T0_CTRL_IDX 8'h0e
`define T1_COUNT_IDX 8'h10
`define T1_CTRL_IDX 8'h11
`define IRQ_CTRL_IDX 8'h12
`define T0_COUNT_ADDR 12'h034
`define T0_CTRL_ADDR 12'h038
`define T1_COUNT_ADDR 12'h040
`define T1_CTRL_ADDR 12'h044
`define IRQ_CTRL_ADDR 12'h048

// ==========================================================
// control fields
`define CTRL_EN_BIT 4
`define CTRL_DIV_MSB 2
`define CTRL_RESET 8'h08
`define CTRL_WMASK 8'h17
`define CTRL_FIXED 8'h80
`define IRQ_T0_BIT 2
`define IRQ_T1_BIT 3

// ==========================================================
// prescaler
`define PRESCALE_BITS 11
`define DIV_BASE_LOG2 4

`endif
